// file: src/ued_defines.vh
// Purpose: Constants of the endpoint descriptor engine.
// Assumes: Byte offsets inside one eight-byte descriptor.
// Notes:   APB byte address is four times the SRAM index.
`ifndef UED_DEFINES_VH
`define UED_DEFINES_VH
`define UED_OFS_STATUS    3'h0
`define UED_OFS_CTRL      3'h1
`define UED_OFS_BYTE_COUNT_LOW      3'h2
`define UED_OFS_BYTE_COUNT_HIGH      3'h3
`define UED_OFS_PTRL      3'h4
`define UED_OFS_PTRH      3'h5
`define UED_OFS_AUXL      3'h6
`define UED_OFS_AUXH      3'h7
`define UED_EP_STRIDE     8'h10
`define UED_IN_OFFSET     8'h08
`define UED_APB_BASE_REG  12'h400
`define UED_APB_STAT_REG  12'h404
`define UED_ST_STALL      7
`define UED_ST_UNF_OVF    6
`define UED_ST_DONE_A     5
`define UED_ST_DONE_B     4
`define UED_ST_BANK       3
`define UED_ST_REFUSE1    2
`define UED_ST_REFUSE0    1
`define UED_ST_TOGGLE     0
`define UED_ST_PLAIN_MASK 8'h41
`define UED_ST_W0C_MASK   8'h32
`define UED_ST_W1C_MASK   8'h8c
`define UED_CT_STALL      2
`define UED_CT_IRQ_MASK   3
`define UED_CT_DBUF       4
`define UED_CT_MULTI      5
`define UED_BYTE_COUNT_HIGH_AUTO_ZERO_LENGTH     7
`define UED_TYPE_OFF      2'h0
`define UED_TYPE_CTRL     2'h1
`define UED_TYPE_BULK     2'h2
`define UED_TYPE_ISO      2'h3
`define UED_TOK_SETUP     2'h0
`define UED_TOK_IN        2'h1
`define UED_TOK_OUT       2'h2
`define UED_HS_NONE       2'h0
`define UED_HS_ACK        2'h1
`define UED_HS_NAK        2'h2
`define UED_HS_STALL      2'h3
`define UED_SIZE_MAX      10'h3ff
`define UED_BASE_RST      16'h0000
`endif

// file: src/ued_ram.v
// Purpose: Descriptor SRAM, 256 bytes, one port.
// Assumes: Write and read share the address; read data is registered.
// Notes:   Contents are undefined after reset, as the descriptors are.
`timescale 1ns/10ps
`default_nettype none
module ued_ram (
   // Clock
   input  wire       ref_clk,
   // Port
   input  wire       we,
   input  wire [7:0] addr,
   input  wire [7:0] wdata,
   output reg  [7:0] rdata
);
   reg [7:0] mem [0:255];

   always @(posedge ref_clk) begin
      if (we) begin
         mem[addr] <= wdata;
      end
      rdata <= mem[addr];
   end
endmodule
`default_nettype wire

// file: src/ued_clip.v
// Purpose: Clips a byte count to a limit.
// Assumes: Unsigned operands.
// Notes:   Flags when the count was cut.
`timescale 1ns/10ps
`default_nettype none
module ued_clip #(
   parameter W = 10
) (
   // Operands
   input  wire [W-1:0] val,
   input  wire [W-1:0] lim,
   // Result
   output wire [W-1:0] res,
   output wire         cut
);
   assign cut = (val > lim);
   assign res = cut ? lim : val;
endmodule
`default_nettype wire

// file: src/ued_core.v
// Purpose: Endpoint descriptor engine, APB access to table.
// Assumes: Tokens arrive on ref_clk.
// Notes:   Summary of operation
// Summary of operation
// [RULE1] Success sets both transaction-done flags; a SETUP success sets only UED_ST_DONE_B here.
// [RULE2] Bank bit toggles per success when double-buffered.
// [RULE3] Buffer 1 refuse flag drops data, NAKs.
// [RULE4] Buffer 0 refuse flag drops data, NAKs.
// [RULE5] Toggle bit gives expected or sent PID.
// [RULE6] Isochronous ignores toggle, sends DATA0 only.
// [RULE7] Type field: off, control, bulk, isochronous.
// [RULE8] Disabled endpoint: only control byte touched.
// [RULE9] Multipacket moves payload without software action.
// [RULE10] Double buffering pairs both descriptors one way; here bank only picks the refuse flag, not the descriptor.
// [RULE11] Software never double-buffers a control endpoint.
// [RULE12] Masked endpoint updates flags, reports nothing.
// [RULE13] Received bytes past max payload discarded.
// [RULE14] Size code maps 8 to 1023 bytes.
// [RULE15] Counter holds received or to-send bytes.
// [RULE16] Auto zero-length bit ends IN transfers.
// [RULE17] Buffer pointer addresses the payload buffer.
// [RULE18] Multipacket IN sums sent bytes in total.
// [RULE19] Software loads OUT transfer total properly.
// [RULE20] Descriptor at base plus sixteen per endpoint.
// [RULE21] STALL answer sets the stall flag.
// [RULE22] Isochronous CRC failure sets the CRC flag.
// [RULE23] Underflow or overflow flag on refusal.
// [RULE24] Control stall bit forces STALL answers.
//
// Design decision made here: register access over APB.
`include "ued_defines.vh"
`timescale 1ns/10ps
`default_nettype none
module ued_core (
   // Clock and reset
   input  wire        ref_clk,
   input  wire        rst_b,
   // APB slave
   input  wire        psel,
   input  wire        penable,
   input  wire        pwrite,
   input  wire [11:0] paddr,
   input  wire [31:0] pwdata,
   output reg  [31:0] prdata,
   output reg         pready,
   output reg         pslverr,
   // Token request
   input  wire        tok_valid,
   output wire        tok_ready,
   input  wire [1:0]  tok_kind,
   input  wire [3:0]  tok_ep,
   input  wire        tok_data1,
   input  wire [9:0]  tok_len,
   input  wire        tok_crc_err,
   // Token answer
   output reg         rsp_valid,
   output reg  [1:0]  rsp_hs,
   output reg         rsp_data1,
   output reg  [9:0]  rsp_len,
   output reg  [15:0] rsp_buf_addr,
   output reg         rsp_drop,
   output reg         done_valid,
   output reg  [15:0] done_desc_addr
);
   localparam S_IDLE = 6'h01;
   localparam S_RD   = 6'h02;
   localparam S_DEC  = 6'h04;
   localparam S_WR   = 6'h08;
   localparam S_ARD  = 6'h10;
   localparam S_AST  = 6'h20;

   reg  [5:0]  state_r;
   reg  [5:0]  state_nxt;
   reg  [3:0]  k_r;
   reg  [15:0] base_r;
   reg  [1:0]  kind_r;
   reg  [3:0]  ep_r;
   reg         data1_r;
   reg  [9:0]  len_r;
   reg         crc_r;
   reg  [7:0]  dsc_r [0:7];
   reg  [1:0]  last_hs_r;
   reg         mem_we;
   reg  [7:0]  mem_addr;
   reg  [7:0]  mem_wd;
   wire [7:0]  mem_rd;
   reg  [2:0]  rd_ofs;
   reg  [2:0]  cap_ofs;
   reg  [2:0]  wr_ofs;
   wire [15:0] desc_addr;
   wire        acc;
   wire        in_ram;
   wire        is_base;
   wire        is_stat;
   wire        is_status_byte;

   // Decision terms.
   wire [7:0]  st;
   wire [7:0]  ct;
   wire [1:0]  typ;
   wire        iso;
   wire        stl;
   wire        bank;
   wire        refuse;
   wire        auto_zero_length;
   wire [2:0]  code;
   reg  [9:0]  maxsz;
   wire [9:0]  cnt;
   wire [15:0] aux;
   wire [15:0] dptr;
   wire [9:0]  remain;
   wire [9:0]  rx_n;
   wire [9:0]  tx_n;
   wire        rx_cut;
   wire [9:0]  sum_out;
   wire [15:0] sum_in;
   reg  [7:0]  st_n;
   reg  [9:0]  cnt_n;
   reg  [15:0] aux_n;
   reg  [1:0]  hs;
   reg         ok;
   reg         fin;
   reg  [9:0]  len_o;
   reg         drop_o;
   reg         d1_o;
   wire [7:0]  st_merge;

   assign tok_ready = (state_r == S_IDLE);
   assign acc       = psel & penable & ~tok_valid;
   assign in_ram    = (paddr[11:10] == 2'h0);
   assign is_base   = ({paddr[11:2], 2'h0} == `UED_APB_BASE_REG);
   assign is_stat   = ({paddr[11:2], 2'h0} == `UED_APB_STAT_REG);
   assign is_status_byte = (paddr[4:2] == `UED_OFS_STATUS);

   // [RULE20] Descriptor address
   assign desc_addr = base_r + {8'h00, ep_r, 4'h0} +
                      ((kind_r == `UED_TOK_IN) ? 16'h0008 : 16'h0000);

   ued_ram u_ram (
      .ref_clk (ref_clk),
      .we      (mem_we),
      .addr    (mem_addr),
      .wdata   (mem_wd),
      .rdata   (mem_rd)
   );

   // [RULE8] Control byte first
   always @* begin
      if (k_r == 4'h0) begin
         rd_ofs = `UED_OFS_CTRL;
      end else if (k_r == 4'h1) begin
         rd_ofs = (mem_rd[7:6] == `UED_TYPE_OFF) ? `UED_OFS_CTRL :
                  `UED_OFS_STATUS;
      end else begin
         rd_ofs = k_r[2:0];
      end
      if (k_r == 4'h1) begin
         cap_ofs = `UED_OFS_CTRL;
      end else if (k_r == 4'h2) begin
         cap_ofs = `UED_OFS_STATUS;
      end else begin
         cap_ofs = k_r[2:0] - 3'h1;
      end
      case (k_r)
         4'h0:    wr_ofs = `UED_OFS_STATUS;
         4'h1:    wr_ofs = `UED_OFS_BYTE_COUNT_LOW;
         4'h2:    wr_ofs = `UED_OFS_BYTE_COUNT_HIGH;
         4'h3:    wr_ofs = `UED_OFS_AUXL;
         default: wr_ofs = `UED_OFS_AUXH;
      endcase
   end

   // Status byte writes keep the per-bit clear conventions.
   // [RULE1] Write-zero clears done
   assign st_merge = (pwdata[7:0] & `UED_ST_PLAIN_MASK) |
                     (mem_rd & pwdata[7:0] & `UED_ST_W0C_MASK) |
                     (mem_rd & ~pwdata[7:0] & `UED_ST_W1C_MASK);

   always @* begin
      mem_we   = 1'b0;
      mem_addr = paddr[9:2];
      mem_wd   = pwdata[7:0];
      case (state_r)
         S_IDLE: begin
            if (acc && in_ram && pwrite && !is_status_byte) begin
               mem_we = 1'b1;
            end
         end
         S_RD: begin
            mem_addr = desc_addr[7:0] + {5'h00, rd_ofs};
         end
         S_WR: begin
            mem_we   = 1'b1;
            mem_addr = desc_addr[7:0] + {5'h00, wr_ofs};
            mem_wd   = dsc_r[wr_ofs];
         end
         S_AST: begin
            mem_we = 1'b1;
            mem_wd = st_merge;
         end
         default: begin
            mem_we = 1'b0;
         end
      endcase
   end

   // Field extraction.
   assign st   = dsc_r[`UED_OFS_STATUS];
   assign ct   = dsc_r[`UED_OFS_CTRL];
   // [RULE7] Endpoint type
   assign typ  = ct[7:6];
   assign iso  = (typ == `UED_TYPE_ISO);
   // [RULE24] Stall bit, absent for isochronous
   assign stl  = ct[`UED_CT_STALL] & ~iso;
   assign code = iso ? ct[2:0] : {1'b0, ct[1:0]};
   assign auto_zero_length = dsc_r[`UED_OFS_BYTE_COUNT_HIGH][`UED_BYTE_COUNT_HIGH_AUTO_ZERO_LENGTH];
   // [RULE15] Ten-bit counter
   assign cnt  = {dsc_r[`UED_OFS_BYTE_COUNT_HIGH][1:0], dsc_r[`UED_OFS_BYTE_COUNT_LOW]};
   assign aux  = {dsc_r[`UED_OFS_AUXH], dsc_r[`UED_OFS_AUXL]};
   assign dptr = {dsc_r[`UED_OFS_PTRH], dsc_r[`UED_OFS_PTRL]};
   // [RULE10] Bank picks buffer
   assign bank = ct[`UED_CT_DBUF] & st[`UED_ST_BANK];
   // [RULE3] [RULE4] Refuse per bank
   assign refuse = bank ? st[`UED_ST_REFUSE1] : st[`UED_ST_REFUSE0];

   // [RULE14] Size code table
   always @* begin
      case (code)
         3'h0:    maxsz = 10'h008;
         3'h1:    maxsz = 10'h010;
         3'h2:    maxsz = 10'h020;
         3'h3:    maxsz = 10'h040;
         3'h4:    maxsz = 10'h080;
         3'h5:    maxsz = 10'h100;
         3'h6:    maxsz = 10'h200;
         default: maxsz = `UED_SIZE_MAX;
      endcase
   end

   assign remain = ct[`UED_CT_MULTI] ? (cnt - aux[9:0]) : cnt;

   // [RULE13] Discard excess bytes
   ued_clip #(.W(10)) u_clip_rx (
      .val (len_r),
      .lim (maxsz),
      .res (rx_n),
      .cut (rx_cut)
   );

   ued_clip #(.W(10)) u_clip_tx (
      .val (remain),
      .lim (maxsz),
      .res (tx_n),
      .cut ()
   );

   assign sum_out = cnt + rx_n;
   assign sum_in  = aux + {6'h00, tx_n};

   always @* begin
      st_n   = st;
      cnt_n  = cnt;
      aux_n  = aux;
      hs     = `UED_HS_NONE;
      ok     = 1'b0;
      fin    = 1'b0;
      len_o  = 10'h000;
      drop_o = 1'b0;
      d1_o   = 1'b0;
      if (kind_r == `UED_TOK_SETUP) begin
         if (typ == `UED_TYPE_CTRL) begin
            cnt_n  = rx_n;
            len_o  = rx_n;
            drop_o = rx_cut;
            hs     = `UED_HS_ACK;
            ok     = 1'b1;
            fin    = 1'b1;
         end
      end else if (stl) begin
         // [RULE21] Stall answered
         hs = `UED_HS_STALL;
         st_n[`UED_ST_STALL] = 1'b1;
      end else if (refuse) begin
         // [RULE23] Not ready flag
         st_n[`UED_ST_UNF_OVF] = 1'b1;
         drop_o = 1'b1;
         hs = iso ? `UED_HS_NONE : `UED_HS_NAK;
      end else if (kind_r == `UED_TOK_OUT) begin
         if (iso && crc_r) begin
            // [RULE22] CRC flag
            st_n[`UED_ST_STALL] = 1'b1;
            drop_o = 1'b1;
         end else if (!iso && (data1_r != st[`UED_ST_TOGGLE])) begin
            // [RULE5] Repeat packet dropped
            hs     = `UED_HS_ACK;
            drop_o = 1'b1;
         end else begin
            hs     = iso ? `UED_HS_NONE : `UED_HS_ACK;
            ok     = 1'b1;
            len_o  = rx_n;
            drop_o = rx_cut;
            // [RULE9] Accumulate until total
            if (ct[`UED_CT_MULTI]) begin
               cnt_n = sum_out;
               fin   = ({6'h00, sum_out} >= aux) || (rx_n < maxsz);
            end else begin
               cnt_n = rx_n;
               fin   = 1'b1;
            end
         end
      end else begin
         hs    = `UED_HS_ACK;
         ok    = 1'b1;
         len_o = tx_n;
         // [RULE6] Isochronous sends DATA0
         d1_o  = iso ? 1'b0 : st[`UED_ST_TOGGLE];
         if (ct[`UED_CT_MULTI]) begin
            // [RULE18] Sum sent bytes
            aux_n = sum_in;
            // [RULE16] Auto zero-length end
            fin   = (tx_n < maxsz) ||
                    (!auto_zero_length && (sum_in >= {6'h00, cnt}));
         end else begin
            fin = 1'b1;
         end
      end
      if (ok) begin
         // [RULE5] Toggle advances
         if (kind_r == `UED_TOK_SETUP) begin
            st_n[`UED_ST_TOGGLE] = 1'b1;
         end else if (!iso) begin
            st_n[`UED_ST_TOGGLE] = ~st[`UED_ST_TOGGLE];
         end
         // [RULE2] Bank toggles
         if (ct[`UED_CT_DBUF]) begin
            st_n[`UED_ST_BANK] = ~st[`UED_ST_BANK];
         end
         // [RULE1] Completion flags
         if (fin) begin
            st_n[`UED_ST_DONE_B] = 1'b1;
            if (kind_r != `UED_TOK_SETUP) begin
               st_n[`UED_ST_DONE_A] = 1'b1;
            end
         end
      end
   end

   always @* begin
      state_nxt = state_r;
      case (state_r)
         S_IDLE: begin
            if (tok_valid) begin
               state_nxt = S_RD;
            end else if (acc && in_ram && !pwrite) begin
               state_nxt = S_ARD;
            end else if (acc && in_ram && is_status_byte) begin
               state_nxt = S_ARD;
            end
         end
         S_RD: begin
            if (k_r == 4'h1 && mem_rd[7:6] == `UED_TYPE_OFF) begin
               state_nxt = S_IDLE;
            end else if (k_r == 4'h8) begin
               state_nxt = S_DEC;
            end
         end
         S_DEC: state_nxt = S_WR;
         S_WR: begin
            if (k_r == 4'h4) begin
               state_nxt = S_IDLE;
            end
         end
         S_ARD: state_nxt = pwrite ? S_AST : S_IDLE;
         S_AST: state_nxt = S_IDLE;
         default: state_nxt = S_IDLE;
      endcase
   end

   // APB answer: own registers and non-status SRAM writes at once, other SRAM after its read.
   always @* begin
      pready  = 1'b0;
      pslverr = 1'b0;
      prdata  = 32'h0000_0000;
      if (state_r == S_IDLE && acc && !in_ram) begin
         pready  = 1'b1;
         pslverr = ~(is_base | is_stat);
         if (is_base) begin
            prdata = {16'h0000, base_r};
         end else if (is_stat) begin
            prdata = {30'h0000_0000, last_hs_r};
         end
      end else if (state_r == S_IDLE && acc && pwrite &&
                   !is_status_byte) begin
         pready = 1'b1;
      end else if (state_r == S_ARD && !pwrite) begin
         pready = 1'b1;
         prdata = {24'h00_0000, mem_rd};
      end else if (state_r == S_AST) begin
         pready = 1'b1;
      end
   end

   always @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b) begin
         state_r        <= S_IDLE;
         k_r            <= 4'h0;
         base_r         <= `UED_BASE_RST;
         kind_r         <= 2'h0;
         ep_r           <= 4'h0;
         data1_r        <= 1'b0;
         len_r          <= 10'h000;
         crc_r          <= 1'b0;
         last_hs_r      <= `UED_HS_NONE;
         rsp_valid      <= 1'b0;
         rsp_hs         <= `UED_HS_NONE;
         rsp_data1      <= 1'b0;
         rsp_len        <= 10'h000;
         rsp_buf_addr   <= 16'h0000;
         rsp_drop       <= 1'b0;
         done_valid     <= 1'b0;
         done_desc_addr <= 16'h0000;
      end else begin
         state_r    <= state_nxt;
         rsp_valid  <= 1'b0;
         done_valid <= 1'b0;
         if (state_r != state_nxt) begin
            k_r <= 4'h0;
         end else begin
            k_r <= k_r + 4'h1;
         end
         if (state_r == S_IDLE && acc && is_base && pwrite) begin
            base_r <= pwdata[15:0];
         end
         if (state_r == S_IDLE && tok_valid) begin
            kind_r  <= tok_kind;
            ep_r    <= tok_ep;
            data1_r <= tok_data1;
            len_r   <= tok_len;
            crc_r   <= tok_crc_err;
         end
         // Disabled endpoint: silent, only the control byte was read.
         if (state_r == S_RD && k_r == 4'h1 &&
             mem_rd[7:6] == `UED_TYPE_OFF) begin
            rsp_valid <= 1'b1;
            rsp_hs    <= `UED_HS_NONE;
            rsp_len   <= 10'h000;
            rsp_drop  <= 1'b1;
            last_hs_r <= `UED_HS_NONE;
         end
         if (state_r == S_DEC) begin
            rsp_valid    <= 1'b1;
            rsp_hs       <= hs;
            rsp_data1    <= d1_o;
            rsp_len      <= len_o;
            rsp_drop     <= drop_o;
            // [RULE17] Payload address
            rsp_buf_addr <= dptr;
            last_hs_r    <= hs;
            // [RULE12] Masked: flags only
            if (ok && fin && !ct[`UED_CT_IRQ_MASK]) begin
               done_valid     <= 1'b1;
               done_desc_addr <= desc_addr;
            end
         end
      end
   end

   // Descriptor copy; contents are data, so no reset is needed.
   always @(posedge ref_clk) begin
      if (state_r == S_RD && k_r != 4'h0) begin
         dsc_r[cap_ofs] <= mem_rd;
      end
      if (state_r == S_DEC) begin
         dsc_r[`UED_OFS_STATUS] <= st_n;
         dsc_r[`UED_OFS_BYTE_COUNT_LOW]   <= cnt_n[7:0];
         dsc_r[`UED_OFS_BYTE_COUNT_HIGH]   <= {dsc_r[`UED_OFS_BYTE_COUNT_HIGH][7:2],
                                    cnt_n[9:8]};
         dsc_r[`UED_OFS_AUXL]   <= aux_n[7:0];
         dsc_r[`UED_OFS_AUXH]   <= aux_n[15:8];
      end
   end
endmodule
`default_nettype wire

// file: test/ued_core_assertions.sv
// Purpose: Port checks of the descriptor engine.
// Assumes: Sees only ued_core ports.
// Notes:   Tracks table base and last token.
`include "ued_defines.vh"
`timescale 1ns/10ps
`default_nettype none
module ued_core_chk (
   // Clock and reset
   input wire logic        ref_clk,
   input wire logic        rst_b,
   // APB
   input wire logic        psel,
   input wire logic        penable,
   input wire logic        pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic        pready,
   input wire logic        pslverr,
   // Tokens
   input wire logic        tok_valid,
   input wire logic        tok_ready,
   input wire logic [1:0]  tok_kind,
   input wire logic [3:0]  tok_ep,
   input wire logic        tok_data1,
   input wire logic [9:0]  tok_len,
   input wire logic        tok_crc_err,
   // Answers
   input wire logic        rsp_valid,
   input wire logic [1:0]  rsp_hs,
   input wire logic        rsp_data1,
   input wire logic [9:0]  rsp_len,
   input wire logic [15:0] rsp_buf_addr,
   input wire logic        rsp_drop,
   input wire logic        done_valid,
   input wire logic [15:0] done_desc_addr
);
   logic [15:0] base_r;
   logic [3:0]  ep_r;
   logic [1:0]  kind_r;
   logic [9:0]  len_r;
   wire         take  = tok_valid && tok_ready;
   wire         acc   = psel && penable && pready;
   wire         unmap = paddr >= 12'h400 && paddr[11:3] != 9'h080;
   wire         is_in = kind_r == `UED_TOK_IN;
   always @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b) begin
         base_r <= 16'h0000;
         ep_r   <= 4'h0;
         kind_r <= 2'h0;
         len_r  <= 10'h000;
      end else begin
         if (acc && pwrite && paddr[11:2] == 10'h100)
            base_r <= pwdata[15:0];
         if (take) begin
            ep_r   <= tok_ep;
            kind_r <= tok_kind;
            len_r  <= tok_len;
         end
      end
   end
   default clocking @(posedge ref_clk); endclocking
   default disable iff (!rst_b);
   a_rsp_pulse: assert property (rsp_valid |=> !rsp_valid)
      else $error("long answer pulse");
   a_done_success: assert property (done_valid |-> rsp_valid &&
      rsp_hs != `UED_HS_NAK && rsp_hs != `UED_HS_STALL)
      else $error("done without success");
   a_answer_time: assert property (take |-> ##[1:12] rsp_valid)
      else $error("token not answered");
   a_refuse_drop: assert property (rsp_valid &&
      rsp_hs == `UED_HS_NAK && !is_in |-> rsp_drop)
      else $error("refused data kept");
   a_len_clip: assert property (rsp_valid && rsp_hs == `UED_HS_ACK &&
      !is_in |-> rsp_len <= len_r && (rsp_drop || rsp_len == len_r))
      else $error("bad accepted length");
   a_desc_addr: assert property (done_valid |-> done_desc_addr ==
      base_r + {8'h00, ep_r, 4'h0} + {12'h000, is_in, 3'h0})
      else $error("bad descriptor address");
   a_disabled_quiet: assert property (take ##[1:3] rsp_valid
      |-> rsp_hs == `UED_HS_NONE && rsp_drop)
      else $error("bad disabled answer");
   a_unmapped_err: assert property (acc && unmap |-> pslverr)
      else $error("no slave error");
   c_take: cover property (take);
   c_done: cover property (done_valid);
   c_stall: cover property (rsp_valid && rsp_hs == `UED_HS_STALL);
   c_err: cover property (acc && pslverr);
endmodule
bind ued_core ued_core_chk u_chk (.ref_clk, .rst_b, .psel, .penable,
   .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .tok_valid,
   .tok_ready, .tok_kind, .tok_ep, .tok_data1, .tok_len, .tok_crc_err,
   .rsp_valid, .rsp_hs, .rsp_data1, .rsp_len, .rsp_buf_addr, .rsp_drop,
   .done_valid, .done_desc_addr);
`default_nettype wire

// file: test/ued_host.sv
// Purpose: Host model issuing tokens.
// Assumes: Call send just after a rising edge.
// Notes:   Released data1 and length lines show inverted values.
`timescale 1ns/10ps
`default_nettype none
module ued_host (
   // Clock
   input  wire logic       ref_clk,
   // Token request
   output var  logic       tok_valid,
   input  wire logic       tok_ready,
   output var  logic [1:0] tok_kind,
   output var  logic [3:0] tok_ep,
   output var  logic       tok_data1,
   output var  logic [9:0] tok_len,
   output var  logic       tok_crc_err,
   // Token answer
   input  wire logic       rsp_valid,
   input  wire logic       done_valid
);
   logic seen_done;
   logic got_rsp;
   initial begin
      tok_valid = 1'b0;
      tok_kind = 2'h0;
      tok_ep = 4'h0;
      tok_data1 = 1'b0;
      tok_len = 10'h000;
      tok_crc_err = 1'b0;
   end
   task automatic send(input logic [1:0] k, input logic [3:0] e,
                       input logic d1, input logic [9:0] n);
      int i;
      tok_valid <= 1'b1;
      tok_kind  <= k;
      tok_ep    <= e;
      tok_data1 <= d1;
      tok_len   <= n;
      do @(posedge ref_clk); while (tok_ready !== 1'b1);
      tok_valid <= 1'b0;
      tok_data1 <= ~d1;
      tok_len   <= ~n;
      got_rsp = 1'b0;
      seen_done = 1'b0;
      for (i = 0; i < 20 && !got_rsp; i++) begin
         @(negedge ref_clk);
         if (rsp_valid === 1'b1) begin
            got_rsp = 1'b1;
            seen_done = done_valid;
         end
      end
      @(posedge ref_clk);
   endtask
endmodule
`default_nettype wire

// file: test/ued_core_tb_top.sv
// Purpose: Self-checking bench of the descriptor engine.
// Assumes: Table base 0x40.
// Notes:   Each task judges its own traffic.
`include "ued_defines.vh"
`timescale 1ns/10ps
`default_nettype none
module ued_core_tb_top;
   localparam int BASE = 'h40;
   logic ref_clk, rst_b, psel, penable, pwrite;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, q;
   logic pready, pslverr, er, tok_valid, tok_ready, tok_data1, tok_crc_err;
   logic [1:0]  tok_kind, rsp_hs;
   logic [3:0]  tok_ep;
   logic [9:0]  tok_len, rsp_len;
   logic rsp_valid, rsp_data1, rsp_drop, done_valid;
   logic [15:0] rsp_buf_addr, done_desc_addr;
   int fail_count = 0;
   int samples_checked = 0;
   int cyc = 0;
   ued_core u_dut (.ref_clk, .rst_b, .psel, .penable, .pwrite, .paddr,
      .pwdata, .prdata, .pready, .pslverr, .tok_valid, .tok_ready,
      .tok_kind, .tok_ep, .tok_data1, .tok_len, .tok_crc_err, .rsp_valid,
      .rsp_hs, .rsp_data1, .rsp_len, .rsp_buf_addr, .rsp_drop,
      .done_valid, .done_desc_addr);
   ued_host u_host (.ref_clk, .tok_valid, .tok_ready, .tok_kind, .tok_ep,
      .tok_data1, .tok_len, .tok_crc_err, .rsp_valid, .done_valid);
   initial begin
      ref_clk = 1'b0;
      forever #2 ref_clk = ~ref_clk;
   end
   task automatic give_verdict;
      $display("checks %0d mismatches %0d", samples_checked, fail_count);
      if (fail_count == 0 && samples_checked > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      samples_checked++;
      if (got !== exp) begin
         fail_count++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic apb(input logic w, input logic [11:0] a,
                      input logic [31:0] d);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge ref_clk);
      penable <= 1'b1;
      do @(posedge ref_clk); while (pready !== 1'b1);
      q = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge ref_clk);
   endtask
   task automatic dwr(input int e, input int d, input int i,
                      input logic [7:0] v);
      apb(1'b1, 12'((BASE + 16 * e + 8 * d + i) * 4), {24'h0, v});
   endtask
   task automatic drd(input int e, input int d, input int i);
      apb(1'b0, 12'((BASE + 16 * e + 8 * d + i) * 4), 32'h0);
   endtask
   // Clears unknown flags, then loads the status byte.
   task automatic sinit(input int e, input int d, input logic [7:0] v);
      dwr(e, d, 0, 8'h8c);
      dwr(e, d, 0, v);
   endtask
   task automatic t_regs;
      apb(1'b0, 12'h400, 32'h0);
      chk(q, 32'h0);
      apb(1'b1, 12'h400, BASE);
      apb(1'b0, 12'h400, 32'h0);
      chk(q, BASE);
      apb(1'b0, 12'h408, 32'h0);
      chk({er, q}, {1'b1, 32'h0});
   endtask
   task automatic t_bulk_out;
      dwr(1, 0, 1, 8'h80);
      sinit(1, 0, 8'h00);
      dwr(1, 0, 4, 8'h34);
      dwr(1, 0, 5, 8'h12);
      u_host.send(`UED_TOK_OUT, 4'h1, 1'b0, 10'd12);
      chk(32'({rsp_hs, rsp_len, rsp_drop}), 32'({`UED_HS_ACK, 10'd8, 1'b1}));
      chk(32'(rsp_buf_addr), 32'h1234);
      chk(32'({u_host.seen_done, done_desc_addr}), 32'h1_0050);
      drd(1, 0, 0);
      chk(q, 32'h31);
      drd(1, 0, 2);
      chk(q, 32'h8);
      u_host.send(`UED_TOK_OUT, 4'h1, 1'b0, 10'd4);
      chk(32'({rsp_hs, rsp_drop}), 32'({`UED_HS_ACK, 1'b1}));
      dwr(1, 0, 0, 8'h30);
      drd(1, 0, 0);
      chk(q, 32'h30);
      dwr(1, 0, 0, 8'h00);
      drd(1, 0, 0);
      chk(q, 32'h00);
   endtask
   task automatic t_stall;
      dwr(2, 0, 1, 8'h84);
      sinit(2, 0, 8'h00);
      u_host.send(`UED_TOK_OUT, 4'h2, 1'b0, 10'd4);
      chk(32'({rsp_hs, u_host.seen_done}), 32'({`UED_HS_STALL, 1'b0}));
      drd(2, 0, 0);
      chk(32'(q[7]), 32'h1);
      dwr(2, 0, 0, 8'h80);
      drd(2, 0, 0);
      chk(32'(q[7]), 32'h0);
   endtask
   task automatic t_disabled;
      dwr(3, 1, 1, 8'h00);
      dwr(3, 1, 4, 8'h5a);
      u_host.send(`UED_TOK_IN, 4'h3, 1'b0, 10'd0);
      chk(32'({rsp_hs, rsp_drop, u_host.seen_done}), 32'({`UED_HS_NONE, 2'b10}));
      drd(3, 1, 4);
      chk(q, 32'h5a);
   endtask
   task automatic t_iso_in;
      dwr(4, 1, 1, 8'hc0);
      sinit(4, 1, 8'h01);
      dwr(4, 1, 2, 8'h04);
      dwr(4, 1, 3, 8'h00);
      u_host.send(`UED_TOK_IN, 4'h4, 1'b0, 10'd0);
      chk(32'({rsp_hs, rsp_data1}), 32'({`UED_HS_ACK, 1'b0}));
      chk(32'(rsp_len), 32'd4);
      chk(32'(done_desc_addr), 32'h88);
   endtask
   task automatic t_masked;
      dwr(5, 0, 1, 8'h88);
      sinit(5, 0, 8'h00);
      u_host.send(`UED_TOK_OUT, 4'h5, 1'b0, 10'd4);
      chk(32'({rsp_hs, u_host.seen_done}), 32'({`UED_HS_ACK, 1'b0}));
      drd(5, 0, 0);
      chk(q, 32'h31);
   endtask
   task automatic t_setup;
      // Software never double-buffers control.
      dwr(0, 0, 1, 8'h43);
      sinit(0, 0, 8'h00);
      u_host.send(`UED_TOK_SETUP, 4'h0, 1'b0, 10'd70);
      chk(32'({rsp_hs, rsp_len, rsp_drop}), 32'({`UED_HS_ACK, 10'd64, 1'b1}));
      chk(32'({u_host.seen_done, done_desc_addr}), 32'h1_0040);
   endtask
   always @(posedge ref_clk) begin
      cyc++;
      if (cyc == 5000) begin
         fail_count++;
         give_verdict();
      end
   end
   initial begin
      rst_b = 1'b0;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 12'h000;
      pwdata = 32'h0;
      repeat (8) @(posedge ref_clk);
      rst_b <= 1'b1;
      @(posedge ref_clk);
      t_regs();
      t_bulk_out();
      t_stall();
      t_disabled();
      t_iso_in();
      t_masked();
      t_setup();
      give_verdict();
   end
endmodule
`default_nettype wire
